// *** hdl/mie_pkg.sv ***
// Package: constants for the memory integrity error trap unit
package mie_pkg;
  // Register byte addresses (AHB word aligned)
  localparam logic [15:0] ADDR_DATA_ASYNC_INFO   = 16'h9018;
  localparam logic [15:0] ADDR_DATA_ERR_LOC      = 16'h901c;
  localparam logic [15:0] ADDR_PROG_ERR_INFO     = 16'h9214;
  localparam logic [15:0] ADDR_PROG_ERR_ADDR     = 16'h9218;
  localparam logic [15:0] ADDR_TRAP_VEC_BASE     = 16'h9300;
  localparam logic [15:0] ADDR_IRQ_STATUS        = 16'h9304;
  localparam logic [15:0] ADDR_IRQ_ENABLE        = 16'h9308;
  localparam logic [15:0] ADDR_IRQ_CLEAR         = 16'h930c;
  localparam logic [15:0] ADDR_CORR_PROG_CNT     = 16'h9310;
  localparam logic [15:0] ADDR_CORR_DATA_CNT     = 16'h9314;
  localparam logic [15:0] ADDR_CONFIG            = 16'h9318;
  // Trap identification
  localparam logic [2:0]  TRAP_CLASS_INTEGRITY   = 3'h4;
  localparam logic [7:0]  TIN_PROG_INTEGRITY     = 8'h05;
  localparam logic [7:0]  TIN_DATA_INTEGRITY     = 8'h06;
  localparam int          CLASS_SHIFT            = 5;
  // Reset values
  localparam logic [31:0] RESET_ZERO             = 32'h0000_0000;
  localparam logic [31:0] BTV_FIELD_MASK         = 32'hffff_fffe;
  // Interrupt status bit positions
  localparam int          IRQ_BITS               = 4;
  localparam int          IRQ_PROG_UNCORR        = 0;
  localparam int          IRQ_DATA_UNCORR        = 1;
  localparam int          IRQ_PROG_CORR          = 2;
  localparam int          IRQ_DATA_CORR          = 3;
  // Config bit positions
  localparam int          CFG_DATA_ASYNC         = 0;
  localparam int          CFG_WRITEBACK          = 1;
  // AHB encodings
  localparam logic [1:0]  HTRANS_NONSEQ          = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ             = 2'h3;
  // Error info field layout
  localparam logic [31:0] INFO_UNCORR_BIT        = 32'h0000_0001;
  localparam logic [31:0] INFO_CORR_BIT          = 32'h0000_0002;
  localparam logic [31:0] INFO_WB_BIT            = 32'h0000_0004;
  localparam logic [31:0] INFO_STORE_BIT         = 32'h0000_0008;
  localparam int          INFO_LANE_LSB          = 8;
  localparam int          LANES                  = 4;
endpackage

// *** hdl/mie_trap_unit.sv ***
// Memory integrity error trap unit with AHB-Lite register slave
//
// Operation
// - Uncorrectable fetch error raises class 4, id 5
// - Program trap tied to the erroneous fetch
// - Any bad fetch-group lane raises program trap
// - Uncorrectable data error raises class 4, id 6
// - Data trap async or sync, chosen by config bit 0
// - Any bad accessed lane raises data trap
// - Unsuppliable data classed uncorrectable
// - Correctable error returns data, no trap
// - Optional write-back makes error resolved
// - Program error info register, resets zero
// - Program error address register holds latest
// - Data asynchronous error info register
// - Data error location register
// - Correctable fetch error bumps program counter
// - Entry address is class shl 5 OR base
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mie_trap_unit
  import mie_pkg::*;
(
  // Clock and reset
  input  wire  logic                 hclk,
  input  wire  logic                 hresetn,
  // AHB-Lite slave
  input  wire  logic                 hsel,
  input  wire  logic [31:0]          haddr,
  input  wire  logic [1:0]           htrans,
  input  wire  logic                 hwrite,
  input  wire  logic [2:0]           hsize,
  input  wire  logic [31:0]          hwdata,
  input  wire  logic                 hready,
  output var   logic [31:0]          hrdata,
  output var   logic                 hreadyout,
  output var   logic                 hresp,
  // Fetch check result from program memory
  input  wire  logic                 fetch_valid,
  input  wire  logic [31:0]          fetch_addr,
  input  wire  logic [mie_pkg::LANES-1:0] fetch_lane_err,
  input  wire  logic [mie_pkg::LANES-1:0] fetch_lane_fix,
  input  wire  logic [31:0]          fetch_tag,
  // Data check result from data memory
  input  wire  logic                 data_valid,
  input  wire  logic                 data_store,
  input  wire  logic [31:0]          data_addr,
  input  wire  logic [mie_pkg::LANES-1:0] data_lane_err,
  input  wire  logic [mie_pkg::LANES-1:0] data_lane_fix,
  input  wire  logic [31:0]          data_tag,
  // Trap to core pipeline
  output var   logic                 program_integrity_trap,
  output var   logic                 data_integrity_trap,
  output var   logic                 data_trap_async,
  output var   logic [7:0]           trap_identification_number,
  output var   logic [2:0]           trap_class,
  output var   logic [31:0]          trap_entry_addr,
  output var   logic [31:0]          trap_tag,
  // Corrected write-back request to memories
  output var   logic                 prog_writeback,
  output var   logic                 data_writeback,
  // Interrupt
  output var   logic                 irq
);
  import mie_pkg::*;

  // Bus state
  logic        ap_write_reg;
  logic [15:0] ap_addr_reg;
  logic        ap_valid_reg;
  logic [31:0] prog_info_reg;
  logic [31:0] prog_addr_reg;
  logic [31:0] data_info_reg;
  logic [31:0] data_loc_reg;
  logic [31:0] btv_reg;
  logic [IRQ_BITS-1:0] irq_status_reg;
  logic [IRQ_BITS-1:0] irq_enable_reg;
  logic [31:0] corr_prog_cnt_reg;
  logic [31:0] corr_data_cnt_reg;
  logic [1:0]  cfg_reg;

  // Per-lane classification: a flagged lane without a fix is uncorrectable
  logic [LANES-1:0] f_uncorr_lane;
  logic [LANES-1:0] d_uncorr_lane;
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      assign f_uncorr_lane[g] = fetch_lane_err[g] & ~fetch_lane_fix[g];
      assign d_uncorr_lane[g] = data_lane_err[g] & ~data_lane_fix[g];
    end
  endgenerate

  // Event decode: whole group or access, not narrowed to one word
  wire f_uncorr = fetch_valid & (|f_uncorr_lane);
  wire d_uncorr = data_valid & (|d_uncorr_lane);
  wire f_corr   = fetch_valid & (|fetch_lane_err) & ~f_uncorr;
  wire d_corr   = data_valid & (|data_lane_err) & ~d_uncorr;
  wire f_any    = f_uncorr | f_corr;
  wire d_any    = d_uncorr | d_corr;
  wire wb_en    = cfg_reg[CFG_WRITEBACK];

  // Info words: class bits, resolved flag, lane map
  wire [31:0] f_info_next = (f_uncorr ? INFO_UNCORR_BIT : INFO_CORR_BIT)
    | ((f_corr & wb_en) ? INFO_WB_BIT : RESET_ZERO)
    | (32'(fetch_lane_err) << INFO_LANE_LSB);
  wire [31:0] d_info_next = (d_uncorr ? INFO_UNCORR_BIT : INFO_CORR_BIT)
    | ((d_corr & wb_en) ? INFO_WB_BIT : RESET_ZERO)
    | (data_store ? INFO_STORE_BIT : RESET_ZERO)
    | (32'(data_lane_err) << INFO_LANE_LSB);

  // Trap selection; program trap wins if both strike in one cycle,
  // data trap then follows from the pending flag next cycle, unless a new program trap takes that cycle and drops it
  logic        d_pend_reg;
  logic [31:0] d_pend_tag_reg;
  wire  d_fire  = d_uncorr | d_pend_reg;
  // Held trap must name the access that failed, not the current one
  wire  [31:0] d_tag_sel = d_pend_reg ? d_pend_tag_reg : data_tag;
  wire  take_p  = f_uncorr;
  wire  take_d  = d_fire & ~f_uncorr;
  wire  [31:0] entry_next = btv_reg
    | (32'(TRAP_CLASS_INTEGRITY) << CLASS_SHIFT);

  // Trap outputs: registered; trap flags are one-cycle pulses, id, class, entry and tag hold until the next trap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      program_integrity_trap     <= 1'b0;
      data_integrity_trap        <= 1'b0;
      data_trap_async            <= 1'b0;
      trap_identification_number <= 8'h00;
      trap_class                 <= 3'h0;
      trap_entry_addr            <= RESET_ZERO;
      trap_tag                   <= RESET_ZERO;
      d_pend_reg                 <= 1'b0;
      d_pend_tag_reg             <= RESET_ZERO;
    end else begin
      program_integrity_trap <= take_p;
      data_integrity_trap    <= take_d;
      data_trap_async        <= take_d & cfg_reg[CFG_DATA_ASYNC];
      d_pend_reg             <= d_uncorr & f_uncorr;
      if (d_uncorr & f_uncorr)
        d_pend_tag_reg <= data_tag;
      if (take_p) begin
        trap_identification_number <= TIN_PROG_INTEGRITY;
        trap_class                 <= TRAP_CLASS_INTEGRITY;
        trap_entry_addr            <= entry_next;
        trap_tag                   <= fetch_tag;
      end else if (take_d) begin
        trap_identification_number <= TIN_DATA_INTEGRITY;
        trap_class                 <= TRAP_CLASS_INTEGRITY;
        trap_entry_addr            <= entry_next;
        trap_tag                   <= d_tag_sel;
      end
    end
  end

  // Corrected value back to memory only when enabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_writeback <= 1'b0;
      data_writeback <= 1'b0;
    end else begin
      prog_writeback <= f_corr & wb_en;
      data_writeback <= d_corr & wb_en;
    end
  end

  // Capture registers: last error always overwrites
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_info_reg <= RESET_ZERO;
      prog_addr_reg <= RESET_ZERO;
      data_info_reg <= RESET_ZERO;
      data_loc_reg  <= RESET_ZERO;
    end else begin
      if (f_any) begin
        prog_info_reg <= f_info_next;
        prog_addr_reg <= fetch_addr;
      end
      if (d_any) begin
        data_info_reg <= d_info_next;
        data_loc_reg  <= data_addr;
      end
    end
  end

  // Correctable counters wrap silently
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      corr_prog_cnt_reg <= RESET_ZERO;
      corr_data_cnt_reg <= RESET_ZERO;
    end else begin
      if (f_corr)
        corr_prog_cnt_reg <= corr_prog_cnt_reg + 32'h1;
      if (d_corr)
        corr_data_cnt_reg <= corr_data_cnt_reg + 32'h1;
    end
  end

  // AHB address phase decode
  wire ap_take = hsel & hready & (htrans == HTRANS_NONSEQ
                                  | htrans == HTRANS_SEQ);
  wire wr_go   = ap_valid_reg & ap_write_reg;
  wire wr_btv  = wr_go & (ap_addr_reg == ADDR_TRAP_VEC_BASE);
  wire wr_ien  = wr_go & (ap_addr_reg == ADDR_IRQ_ENABLE);
  wire wr_iclr = wr_go & (ap_addr_reg == ADDR_IRQ_CLEAR);
  wire wr_cfg  = wr_go & (ap_addr_reg == ADDR_CONFIG);
  wire [IRQ_BITS-1:0] irq_set = {d_corr, f_corr, d_uncorr, f_uncorr};
  wire [IRQ_BITS-1:0] irq_clr = wr_iclr ? hwdata[IRQ_BITS-1:0]
                                        : {IRQ_BITS{1'b0}};
  // Set wins over a clear in the same cycle
  wire [IRQ_BITS-1:0] status_next = (irq_status_reg & ~irq_clr) | irq_set;

  // Read mux for the data phase; unmapped reads return zero
  logic [31:0] rd_mux;
  always_comb begin
    case (haddr[15:0])
      ADDR_DATA_ASYNC_INFO: rd_mux = data_info_reg;
      ADDR_DATA_ERR_LOC:    rd_mux = data_loc_reg;
      ADDR_PROG_ERR_INFO:   rd_mux = prog_info_reg;
      ADDR_PROG_ERR_ADDR:   rd_mux = prog_addr_reg;
      ADDR_TRAP_VEC_BASE:   rd_mux = btv_reg;
      ADDR_IRQ_STATUS:      rd_mux = 32'(irq_status_reg);
      ADDR_IRQ_ENABLE:      rd_mux = 32'(irq_enable_reg);
      ADDR_CORR_PROG_CNT:   rd_mux = corr_prog_cnt_reg;
      ADDR_CORR_DATA_CNT:   rd_mux = corr_data_cnt_reg;
      ADDR_CONFIG:          rd_mux = 32'(cfg_reg);
      default:              rd_mux = RESET_ZERO;
    endcase
  end

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg  <= 16'h0000;
      hrdata       <= RESET_ZERO;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
    end else begin
      ap_valid_reg <= ap_take;
      ap_write_reg <= hwrite;
      ap_addr_reg  <= haddr[15:0];
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      if (ap_take & ~hwrite)
        hrdata <= rd_mux;
    end
  end

  // Software registers and interrupt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      btv_reg        <= RESET_ZERO;
      irq_enable_reg <= {IRQ_BITS{1'b0}};
      irq_status_reg <= {IRQ_BITS{1'b0}};
      cfg_reg        <= 2'h0;
      irq            <= 1'b0;
    end else begin
      if (wr_btv)
        btv_reg <= hwdata & BTV_FIELD_MASK;   // Bit 0 reserved, reads zero
      if (wr_ien)
        irq_enable_reg <= hwdata[IRQ_BITS-1:0];
      if (wr_cfg)
        cfg_reg <= hwdata[1:0];
      irq_status_reg <= status_next;
      irq <= |(status_next & (wr_ien ? hwdata[IRQ_BITS-1:0]
                                     : irq_enable_reg));
    end
  end

  // Checks
  property p_prog_trap;
    @(posedge hclk) disable iff (!hresetn)
    f_uncorr |=> program_integrity_trap
      && trap_identification_number == TIN_PROG_INTEGRITY
      && trap_class == TRAP_CLASS_INTEGRITY;
  endproperty
  a_prog_trap: assert property (p_prog_trap)
    else $error("program trap missing or wrong id");

  property p_prog_tag;
    @(posedge hclk) disable iff (!hresetn)
    f_uncorr |=> trap_tag == $past(fetch_tag);
  endproperty
  a_prog_tag: assert property (p_prog_tag)
    else $error("program trap not tied to its fetch");

  property p_group;
    @(posedge hclk) disable iff (!hresetn)
    (fetch_valid && |(fetch_lane_err & ~fetch_lane_fix))
      |=> program_integrity_trap;
  endproperty
  a_group: assert property (p_group)
    else $error("bad lane in fetch group gave no trap");

  sequence s_data_bad;
    data_valid && |(data_lane_err & ~data_lane_fix);
  endsequence
  property p_data_trap;
    @(posedge hclk) disable iff (!hresetn)
    s_data_bad |-> ##[1:2] (data_integrity_trap
      && trap_identification_number == TIN_DATA_INTEGRITY);
  endproperty
  a_data_trap: assert property (p_data_trap)
    else $error("data trap missing or wrong id");

  property p_async;
    @(posedge hclk) disable iff (!hresetn)
    data_trap_async |-> data_integrity_trap && cfg_reg[CFG_DATA_ASYNC];
  endproperty
  a_async: assert property (p_async)
    else $error("async flag without data trap");

  property p_corr_no_trap;
    @(posedge hclk) disable iff (!hresetn)
    (f_corr && !d_fire) |=> !program_integrity_trap && !data_integrity_trap;
  endproperty
  a_corr_no_trap: assert property (p_corr_no_trap)
    else $error("correctable error raised a trap");

  property p_cnt;
    @(posedge hclk) disable iff (!hresetn)
    f_corr |=> corr_prog_cnt_reg == $past(corr_prog_cnt_reg) + 32'h1;
  endproperty
  a_cnt: assert property (p_cnt)
    else $error("program counter did not advance");

  property p_capture;
    @(posedge hclk) disable iff (!hresetn)
    f_any |=> prog_addr_reg == $past(fetch_addr)
      && prog_info_reg != RESET_ZERO;
  endproperty
  a_capture: assert property (p_capture)
    else $error("program address not captured");

  property p_entry;
    @(posedge hclk) disable iff (!hresetn)
    program_integrity_trap |-> trap_entry_addr ==
      ($past(btv_reg) | (32'(TRAP_CLASS_INTEGRITY) << CLASS_SHIFT));
  endproperty
  a_entry: assert property (p_entry)
    else $error("wrong trap entry address");

  // Collision: program trap first, held data trap one cycle later
  sequence s_collide;
    f_uncorr && d_uncorr;
  endsequence
  property p_pend_tag;
    @(posedge hclk) disable iff (!hresetn)
    s_collide |-> ##1 (program_integrity_trap && !data_integrity_trap)
      ##1 (data_integrity_trap && trap_tag == $past(data_tag, 2));
  endproperty
  a_pend_tag: assert property (p_pend_tag)
    else $error("held data trap lost or wrong tag");

  property p_wb;
    @(posedge hclk) disable iff (!hresetn)
    f_corr |=> prog_writeback == $past(wb_en);
  endproperty
  a_wb: assert property (p_wb)
    else $error("write-back request does not follow enable");

  property p_data_corr;
    @(posedge hclk) disable iff (!hresetn)
    (d_corr && !d_pend_reg) |=> !data_integrity_trap;
  endproperty
  a_data_corr: assert property (p_data_corr)
    else $error("correctable data error raised a trap");

  property p_data_cap;
    @(posedge hclk) disable iff (!hresetn)
    d_any |=> data_loc_reg == $past(data_addr)
      && data_info_reg != RESET_ZERO;
  endproperty
  a_data_cap: assert property (p_data_cap)
    else $error("data error location not captured");
endmodule
`default_nettype wire

// *** tb/mie_mem_model.sv ***
// Partner model: local memories reporting integrity check results
`timescale 1ns/1ps
`default_nettype none
module mie_mem_model
  import mie_pkg::*;
(
  // Clock
  input  wire logic                      hclk,
  // Fetch check result
  output var  logic                      fetch_valid,
  output var  logic [31:0]               fetch_addr,
  output var  logic [mie_pkg::LANES-1:0] fetch_lane_err,
  output var  logic [mie_pkg::LANES-1:0] fetch_lane_fix,
  output var  logic [31:0]               fetch_tag,
  // Data check result
  output var  logic                      data_valid,
  output var  logic                      data_store,
  output var  logic [31:0]               data_addr,
  output var  logic [mie_pkg::LANES-1:0] data_lane_err,
  output var  logic [mie_pkg::LANES-1:0] data_lane_fix,
  output var  logic [31:0]               data_tag
);
  // Idle values at time zero
  initial begin
    {fetch_valid, data_valid, data_store} = 3'h0;
    {fetch_addr, fetch_tag, data_addr, data_tag} = 128'h0;
    {fetch_lane_err, fetch_lane_fix} = 8'h0;
    {data_lane_err, data_lane_fix} = 8'h0;
  end

  // One fetch group after lat idle cycles; lines inverted once idle
  // so a result read outside its valid cycle shows up as garbage
  task automatic fetch(input logic [31:0] a, input logic [3:0] e,
                       input logic [3:0] f, input logic [31:0] t,
                       input int lat);
    repeat (lat + 1) @(posedge hclk);
    fetch_valid <= 1'b1;
    {fetch_addr, fetch_lane_err, fetch_lane_fix, fetch_tag} <= {a, e, f, t};
    @(posedge hclk);
    fetch_valid <= 1'b0;
    {fetch_addr, fetch_lane_err, fetch_lane_fix, fetch_tag} <= ~{a, e, f, t};
  endtask

  // One load or store check, same shape as a fetch
  task automatic data(input logic [31:0] a, input logic s,
                      input logic [3:0] e, input logic [3:0] f,
                      input logic [31:0] t, input int lat);
    repeat (lat + 1) @(posedge hclk);
    data_valid <= 1'b1;
    {data_store, data_addr, data_lane_err, data_lane_fix, data_tag}
      <= {s, a, e, f, t};
    @(posedge hclk);
    data_valid <= 1'b0;
    {data_store, data_addr, data_lane_err, data_lane_fix, data_tag}
      <= ~{s, a, e, f, t};
  endtask
endmodule
`default_nettype wire

// *** tb/tb_mie_trap_unit.sv ***
// Testbench for the memory integrity error trap unit
`timescale 1ns/1ps
`default_nettype none
module tb_mie_trap_unit;
  import mie_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0]  htrans;
  logic [2:0]  hsize, trap_class;
  wire logic   hready;
  logic        fetch_valid, data_valid, data_store;
  logic [31:0] fetch_addr, fetch_tag, data_addr, data_tag;
  logic [3:0]  fetch_lane_err, fetch_lane_fix, data_lane_err, data_lane_fix;
  logic        program_integrity_trap, data_integrity_trap, data_trap_async;
  logic        prog_writeback, data_writeback;
  logic [7:0]  trap_identification_number;
  logic [31:0] trap_entry_addr, trap_tag;
  int          num_errors, num_checks;

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;

  mie_trap_unit i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .fetch_valid,
    .fetch_addr, .fetch_lane_err, .fetch_lane_fix, .fetch_tag, .data_valid,
    .data_store, .data_addr, .data_lane_err, .data_lane_fix, .data_tag,
    .program_integrity_trap, .data_integrity_trap, .data_trap_async,
    .trap_identification_number, .trap_class, .trap_entry_addr, .trap_tag,
    .prog_writeback, .data_writeback, .irq);

  mie_mem_model i_mem (.hclk, .fetch_valid, .fetch_addr, .fetch_lane_err,
    .fetch_lane_fix, .fetch_tag, .data_valid, .data_store, .data_addr,
    .data_lane_err, .data_lane_fix, .data_tag);

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for ready sampled high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 100) begin
        num_errors++;
        wrap_up();
      end
      @(posedge hclk);
    end
  endtask

  // One single word transfer; read data taken at the data phase edge
  task automatic ahb(input logic w, input logic [15:0] a,
                     input logic [31:0] wd);
    @(posedge hclk);
    htrans <= HTRANS_NONSEQ;
    haddr  <= {16'h0000, a};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rdv = hrdata;
  endtask

  task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    chk(rdv, exp);
    chk(32'(hresp), 32'h0000_0000);
  endtask

  // Pulse outputs one cycle after the request, gone the cycle after
  task automatic tvec(input logic [3:0] exp);
    #1;
    chk({28'h0, program_integrity_trap, data_integrity_trap,
         data_trap_async, prog_writeback | data_writeback}, {28'h0, exp});
  endtask

  task automatic ptrap(input logic [3:0] exp);
    tvec(exp);
    @(posedge hclk);
    tvec(4'h0);
  endtask

  task automatic wirq(input logic v);
    int n;
    for (n = 0; n < 8 && irq !== v; n++) @(posedge hclk);
    #1;
    chk(32'(irq), 32'(v));
  endtask

  // Clock
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // Main sequence
  initial begin
    {hresetn, hwrite, htrans, haddr, hwdata} = '0;
    hsel = 1'b1;
    hsize = 3'h2;
    num_errors = 0;
    num_checks = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(ADDR_PROG_ERR_INFO, RESET_ZERO);
    rchk(ADDR_PROG_ERR_ADDR, RESET_ZERO);
    rchk(16'h9400, 32'h0000_0000);
    wr_base: ahb(1'b1, ADDR_TRAP_VEC_BASE, 32'h0000_0401);
    rchk(ADDR_TRAP_VEC_BASE, 32'h0000_0400);
    ahb(1'b1, ADDR_IRQ_ENABLE, 32'h0000_0001);
    // Uncorrectable fetch, one bad lane in the group
    i_mem.fetch(32'hc000_0010, 4'h4, 4'h0, 32'h1234_5678, 0);
    ptrap(4'h8);
    chk(32'(trap_identification_number), 32'(TIN_PROG_INTEGRITY));
    chk(32'(trap_class), 32'h0000_0004);
    chk(trap_entry_addr, 32'h0000_0480);
    chk(trap_tag, 32'h1234_5678);
    wirq(1'b1);
    rchk(ADDR_PROG_ERR_INFO, 32'h0000_0401);
    rchk(ADDR_PROG_ERR_ADDR, 32'hc000_0010);
    rchk(ADDR_IRQ_STATUS, 32'h0000_0001);
    ahb(1'b1, ADDR_IRQ_CLEAR, 32'h0000_0001);
    wirq(1'b0);
    // Async store error, delayed answer; masked until enabled
    ahb(1'b1, ADDR_CONFIG, 32'h0000_0003);
    i_mem.data(32'hd000_0020, 1'b1, 4'h8, 4'h0, 32'h0bad_0001, 3);
    ptrap(4'h6);
    chk(32'(trap_identification_number), 32'(TIN_DATA_INTEGRITY));
    chk(trap_tag, 32'h0bad_0001);
    rchk(ADDR_IRQ_STATUS, 32'h0000_0002);
    chk(32'(irq), 32'h0000_0000);
    rchk(ADDR_DATA_ASYNC_INFO, 32'h0000_0809);
    rchk(ADDR_DATA_ERR_LOC, 32'hd000_0020);
    ahb(1'b1, ADDR_IRQ_ENABLE, 32'h0000_0003);
    wirq(1'b1);
    ahb(1'b1, ADDR_IRQ_CLEAR, 32'h0000_0002);
    wirq(1'b0);
    // Correctable errors: data returned, written back, counted
    i_mem.fetch(32'hc000_0040, 4'h2, 4'h2, 32'h0000_0077, 1);
    ptrap(4'h1);
    rchk(ADDR_CORR_PROG_CNT, 32'h0000_0001);
    rchk(ADDR_PROG_ERR_INFO, 32'h0000_0206);
    rchk(ADDR_PROG_ERR_ADDR, 32'hc000_0040);
    i_mem.data(32'hd000_0044, 1'b0, 4'h1, 4'h1, 32'h0000_0088, 0);
    ptrap(4'h1);
    rchk(ADDR_CORR_DATA_CNT, 32'h0000_0001);
    // Write-back off, sync data trap: error left unresolved
    ahb(1'b1, ADDR_CONFIG, 32'h0000_0000);
    i_mem.fetch(32'hc000_0050, 4'h2, 4'h2, 32'h0000_0055, 0);
    ptrap(4'h0);
    rchk(ADDR_PROG_ERR_INFO, 32'h0000_0202);
    rchk(ADDR_CORR_PROG_CNT, 32'h0000_0002);
    // Both memories fail in one cycle: data trap held one cycle
    fork
      i_mem.fetch(32'hc000_00c0, 4'h1, 4'h0, 32'h0000_00aa, 0);
      i_mem.data(32'hd000_00c4, 1'b0, 4'h1, 4'h0, 32'h0000_00bb, 0);
    join
    tvec(4'h8);
    chk(trap_tag, 32'h0000_00aa);
    @(posedge hclk);
    tvec(4'h4);
    chk(trap_tag, 32'h0000_00bb);
    chk(32'(trap_identification_number), 32'(TIN_DATA_INTEGRITY));
    // A lane the memory could not repair still traps
    i_mem.fetch(32'hc000_0080, 4'h6, 4'h2, 32'h0000_0099, 0);
    ptrap(4'h8);
    // Reset in mid-run clears capture and interrupt state
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    tvec(4'h0);
    chk(32'(irq), 32'h0000_0000);
    rchk(ADDR_PROG_ERR_INFO, RESET_ZERO);
    rchk(ADDR_CORR_PROG_CNT, 32'h0000_0000);
    wrap_up();
  end
endmodule
`default_nettype wire
